// >>> design/acs_cfg.svh
// Register map, field positions, reset values of the accumulator slice
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define ACS_OFF_CMD     12'h000
`define ACS_OFF_ACC     12'h004
`define ACS_OFF_OPND    12'h008
`define ACS_OFF_FIELD   12'h00C
`define ACS_OFF_STATUS  12'h010
`define ACS_OFF_TOP     12'h014
`define ACS_OFF_BITS    4'h1

// ****************************************
// Field positions and limits
// ****************************************
`define ACS_CMD_OP_MSB    2
`define ACS_FLD_START_MSB 7
`define ACS_FLD_CNT_LSB   8
`define ACS_FLD_CNT_MSB   13
`define ACS_CNT_MIN       6'h01
`define ACS_CNT_MAX       6'h20
`define ACS_ST_LT         0
`define ACS_ST_EQ         1
`define ACS_ST_GT         2
`define ACS_ST_ZERO       3
`define ACS_ST_NEG        4

// ****************************************
// Reset values
// ****************************************
`define ACS_RST_WORD      32'h0000_0000
`define ACS_RST_FIELD     14'h0101

`endif

// >>> design/acs_pkg.sv
// Types shared by the accumulator slice modules
package acs_pkg;

	typedef enum logic [2:0] {
		ACS_OP_NONE  = 3'b000,
		ACS_OP_SXOR  = 3'b001,
		ACS_OP_WCMP  = 3'b010,
		ACS_OP_DCMP  = 3'b011,
		ACS_OP_FCMP  = 3'b100,
		ACS_OP_SCMP  = 3'b101
	} acs_op_t;

endpackage : acs_pkg

// >>> design/acs_cmp_if.sv
// Operand and result bundle between datapath and comparator
`timescale 1ns/1ns
interface acs_cmp_if;
	logic [31:0] lhs;
	logic [31:0] rhs;
	logic        lt;
	logic        eq;
	logic        gt;
	modport dp  (output lhs, output rhs, input lt, input eq, input gt);
	modport cmp (input lhs, input rhs, output lt, output eq, output gt);
endinterface : acs_cmp_if

// >>> design/acs_cmp.sv
// Unsigned magnitude comparator for all compare instructions
`timescale 1ns/1ns
module acs_cmp import acs_pkg::*; (
	// Operands and result
	acs_cmp_if.cmp c
);

	// ****************************************
	// Magnitude compare
	// ****************************************
	// Unsigned order also orders packed BCD of like format
	assign c.eq = (c.lhs == c.rhs);
	assign c.lt = (c.lhs <  c.rhs);
	assign c.gt = !c.eq && !c.lt;

endmodule : acs_cmp

// >>> design/acs_top.sv
// Accumulator xor-with-stack and compare datapath with APB access
`timescale 1ns/1ns
`include "acs_cfg.svh"
module acs_top import acs_pkg::*; #(
	parameter int STACK_DEPTH = 8,
	parameter int BIT_WORDS   = 8
) (
	// Clock and reset
	input  wire  logic        pclk,
	input  wire  logic        presetn,
	// APB slave
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [11:0] paddr,
	input  wire  logic [31:0] pwdata,
	output logic        [31:0] prdata,
	output logic               pready,
	output logic               pslverr,
	// Status flags to the sequencer
	output logic               less_than_flag,
	output logic               equal_flag,
	output logic               greater_than_flag,
	output logic               zero_result_flag,
	output logic               negative_result_flag
);

	localparam int BIT_W = BIT_WORDS * 32;
	localparam int IDX_W = $clog2(BIT_W);

	// ****************************************
	// State
	// ****************************************
	logic [31:0]     acc_q;
	logic [31:0]     opnd_q;
	logic [13:0]     field_q;
	logic [31:0]     stack_q [STACK_DEPTH];
	logic [31:0]     bits_q  [BIT_WORDS];
	logic            pready_q;
	logic            pslverr_q;
	logic [31:0]     prdata_q;
	logic            lt_q;
	logic            eq_q;
	logic            gt_q;
	logic            zero_q;
	logic            neg_q;
	logic [BIT_W-1:0] bits_flat;

	acs_cmp_if cmp_bus ();

	acs_cmp u_cmp (
		.c (cmp_bus.cmp)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	wire         access    = psel && penable && pready_q;
	wire         acc_hit   = paddr == `ACS_OFF_ACC;
	wire         cmd_hit   = paddr == `ACS_OFF_CMD;
	wire         opnd_hit  = paddr == `ACS_OFF_OPND;
	wire         field_hit = paddr == `ACS_OFF_FIELD;
	wire         stat_hit  = paddr == `ACS_OFF_STATUS;
	wire         top_hit   = paddr == `ACS_OFF_TOP;
	wire         bits_hit  = (paddr[11:8] == `ACS_OFF_BITS)
	                         && (int'(paddr[7:2]) < BIT_WORDS)
	                         && (paddr[1:0] == 2'h0);
	wire         reg_hit   = acc_hit || cmd_hit || opnd_hit || field_hit;
	wire         ro_hit    = stat_hit || top_hit;
	wire [2:0]   bit_sel   = paddr[4:2];
	wire [5:0]   bit_word  = paddr[7:2];
	wire [5:0]   fld_cnt   = field_q[`ACS_FLD_CNT_MSB:`ACS_FLD_CNT_LSB];
	wire [7:0]   fld_start = field_q[`ACS_FLD_START_MSB:0];
	wire         cnt_ok    = (fld_cnt >= `ACS_CNT_MIN)
	                         && (fld_cnt <= `ACS_CNT_MAX);
	acs_op_t     op;
	assign op = acs_op_t'(pwdata[`ACS_CMD_OP_MSB:0]);
	wire         op_ok     = (op == ACS_OP_SXOR) || (op == ACS_OP_WCMP)
	                         || (op == ACS_OP_DCMP) || (op == ACS_OP_SCMP)
	                         || ((op == ACS_OP_FCMP) && cnt_ok);
	// Bad opcode or bit count is refused, nothing changes
	wire         bad       = (pwrite && ro_hit) || (pwrite && cmd_hit && !op_ok)
	                         || !(reg_hit || ro_hit || bits_hit);
	wire         wr_ok     = access && pwrite && !bad;
	wire         acc_wr    = wr_ok && acc_hit;
	wire         go        = wr_ok && cmd_hit;
	wire         go_xor    = go && (op == ACS_OP_SXOR);
	wire         go_cmp    = go && (op != ACS_OP_SXOR);

	// ****************************************
	// Operand selection
	// ****************************************
	function automatic logic [31:0] gather(
		input logic [BIT_W-1:0] mem,
		input logic [7:0]       start,
		input logic [5:0]       cnt
	);
		logic [IDX_W-1:0] idx;
		logic [31:0]      v;
		v   = 32'h0000_0000;
		idx = '0;
		for (int i = 0; i < 32; i++) begin
			idx = IDX_W'(start + i);
			if (i < int'(cnt)) begin
				v[i] = mem[idx];
			end
		end
		return v;
	endfunction : gather

	for (genvar w = 0; w < BIT_WORDS; w++) begin : g_flat
		assign bits_flat[w*32 +: 32] = bits_q[w];
	end

	wire [31:0] field_val = gather(bits_flat, fld_start, fld_cnt);
	wire [31:0] xor_res   = acc_q ^ stack_q[0];
	wire        word_eq   = acc_q[15:0] == opnd_q[15:0];

	// Word compare sees only the low half of both sides
	assign cmp_bus.lhs = (op == ACS_OP_WCMP) ?
	                     {16'h0000, acc_q[15:0]} : acc_q;
	assign cmp_bus.rhs = (op == ACS_OP_WCMP) ? {16'h0000, opnd_q[15:0]} :
	                     (op == ACS_OP_DCMP) ? opnd_q :
	                     (op == ACS_OP_FCMP) ? field_val :
	                     stack_q[0];

	// ****************************************
	// Read data
	// ****************************************
	wire [31:0] status_val = {27'h0, neg_q, zero_q, gt_q, eq_q, lt_q};
	wire [31:0] rd_data =
		acc_hit   ? acc_q :
		opnd_hit  ? opnd_q :
		field_hit ? {18'h0, field_q} :
		stat_hit  ? status_val :
		top_hit   ? stack_q[0] :
		bits_hit  ? bits_q[bit_word[2:0]] :
		32'h0000_0000;

	// ****************************************
	// APB handshake
	// ****************************************
	// One wait state keeps every answer straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= `ACS_RST_WORD;
		end else begin
			pready_q  <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && bad;
			prdata_q  <= (psel && !pwrite && !bad) ? rd_data : `ACS_RST_WORD;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opnd_q  <= `ACS_RST_WORD;
			field_q <= `ACS_RST_FIELD;
		end else if (wr_ok && opnd_hit) begin
			opnd_q  <= pwdata;
		end else if (wr_ok && field_hit) begin
			field_q <= pwdata[13:0];
		end
	end

	for (genvar w = 0; w < BIT_WORDS; w++) begin : g_bits
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				bits_q[w] <= `ACS_RST_WORD;
			end else if (wr_ok && bits_hit && (bit_sel == 3'(w))) begin
				bits_q[w] <= pwdata;
			end
		end
	end

	// ****************************************
	// Accumulator and stack
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= `ACS_RST_WORD;
		end else if (acc_wr) begin
			acc_q <= pwdata;
		end else if (go_xor) begin
			acc_q <= xor_res;
		end
	end

	for (genvar s = 0; s < STACK_DEPTH; s++) begin : g_stack
		logic [31:0] push_in;
		logic [31:0] pop_in;
		if (s == 0) begin : g_first
			assign push_in = acc_q;
		end else begin : g_rest
			assign push_in = stack_q[s-1];
		end
		if (s == STACK_DEPTH - 1) begin : g_last
			assign pop_in = `ACS_RST_WORD;
		end else begin : g_inner
			assign pop_in = stack_q[s+1];
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stack_q[s] <= `ACS_RST_WORD;
			end else if (acc_wr) begin
				stack_q[s] <= push_in;
			end else if (go_xor) begin
				stack_q[s] <= pop_in;
			end
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	// Each flag group moves only on its own instructions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_q <= 1'b0;
			neg_q  <= 1'b0;
		end else if (go_xor) begin
			zero_q <= xor_res == 32'h0000_0000;
			neg_q  <= xor_res[31];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lt_q <= 1'b0;
			eq_q <= 1'b0;
			gt_q <= 1'b0;
		end else if (go_cmp) begin
			lt_q <= cmp_bus.lt;
			eq_q <= cmp_bus.eq;
			gt_q <= cmp_bus.gt;
		end
	end

	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign less_than_flag       = lt_q;
	assign equal_flag           = eq_q;
	assign greater_than_flag    = gt_q;
	assign zero_result_flag     = zero_q;
	assign negative_result_flag = neg_q;

	// ****************************************
	// Checks
	// ****************************************
	property p_xor_acc;
		@(posedge pclk) disable iff (!presetn)
		go_xor |=> acc_q == $past(xor_res);
	endproperty
	a_xor_acc: assert property (p_xor_acc)
		else $error("stack xor result not in accumulator");

	property p_xor_pop;
		@(posedge pclk) disable iff (!presetn)
		go_xor |=> stack_q[0] == $past(stack_q[1]);
	endproperty
	a_xor_pop: assert property (p_xor_pop)
		else $error("stack did not move up after xor");

	property p_xor_zero;
		@(posedge pclk) disable iff (!presetn)
		go_xor |=> zero_q == (acc_q == 32'h0000_0000);
	endproperty
	a_xor_zero: assert property (p_xor_zero)
		else $error("zero flag disagrees with accumulator");

	property p_xor_neg;
		@(posedge pclk) disable iff (!presetn)
		go_xor |=> neg_q == acc_q[31];
	endproperty
	a_xor_neg: assert property (p_xor_neg)
		else $error("negative flag disagrees with accumulator");

	property p_flag_hold;
		@(posedge pclk) disable iff (!presetn)
		!go ##1 !go |=> $stable({lt_q, eq_q, gt_q, zero_q, neg_q});
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag moved without an instruction");

	property p_word_eq;
		@(posedge pclk) disable iff (!presetn)
		go && (op == ACS_OP_WCMP) |=> eq_q == $past(word_eq);
	endproperty
	a_word_eq: assert property (p_word_eq)
		else $error("word compare did not use low halves");

	property p_onehot;
		@(posedge pclk) disable iff (!presetn)
		go_cmp |=> $onehot({lt_q, eq_q, gt_q}) [*2];
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("compare flags not exactly one");

	property p_scmp_keep;
		@(posedge pclk) disable iff (!presetn)
		go && (op == ACS_OP_SCMP) |=> acc_q == $past(acc_q);
	endproperty
	a_scmp_keep: assert property (p_scmp_keep)
		else $error("stack compare changed accumulator");

	property p_push;
		@(posedge pclk) disable iff (!presetn)
		acc_wr |=> stack_q[0] == $past(acc_q) && acc_q == $past(pwdata);
	endproperty
	a_push: assert property (p_push)
		else $error("load did not push previous accumulator");

endmodule : acs_top

// >>> tb/acs_seq_model.sv
// Sequencer model: APB master that issues loads and instructions
`timescale 1ns/1ns
module acs_seq_model (
	// Clock
	input  wire  logic        pclk,
	// APB master side
	output logic              psel,
	output logic              penable,
	output logic              pwrite,
	output logic       [11:0] paddr,
	output logic       [31:0] pwdata,
	input  wire  logic [31:0] prdata,
	input  wire  logic        pready,
	input  wire  logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// ****************************************
	// One transfer, waits on pready with no cycle count
	// ****************************************
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? d : ~pwdata;
		@(posedge pclk);
		penable <= 1'b1;
		forever begin
			@(posedge pclk);
			if (pready)
				break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data is scrambled so a stale value is never trusted
		pwdata <= ~pwdata;
	endtask : xfer
endmodule : acs_seq_model

// >>> tb/accum_compare_xor_stack_tb_top.sv
// Self-checking bench for the accumulator xor and compare slice
`timescale 1ns/1ns
module accum_compare_xor_stack_tb_top;
	import acs_pkg::*;
	logic              pclk;
	logic              presetn;
	wire logic         psel, penable, pwrite, pready, pslverr;
	wire logic [11:0]  paddr;
	wire logic [31:0]  pwdata, prdata;
	wire logic         lt, eq, gt, zr, ng;
	logic [31:0]       acc_m, opnd, lf, r;
	logic [7:0][31:0]  stk;
	logic [255:0]      bm;
	logic [4:0]        f_m;
	logic [7:0]        st;
	logic [5:0]        cnt;
	logic              e;
	int                miscompares, n_checks;

	acs_top #(.STACK_DEPTH(8), .BIT_WORDS(8)) acs_top_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .less_than_flag(lt), .equal_flag(eq),
		.greater_than_flag(gt), .zero_result_flag(zr),
		.negative_result_flag(ng));
	acs_seq_model acs_seq_model_inst (.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	// ****************************************
	// Expectation helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [2:0] rel(input logic [31:0] a,
		input logic [31:0] b);
		return (a < b) ? 3'h1 : ((a == b) ? 3'h2 : 3'h4);
	endfunction : rel

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// ****************************************
	// Bus and instruction tasks
	// ****************************************
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		acs_seq_model_inst.xfer(1'b1, a, d, r, e);
		check("pslverr", {31'h0, e}, 32'h0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		acs_seq_model_inst.xfer(1'b0, a, 32'h0, r, e);
		check($sformatf("read %h", a), r, x);
	endtask : rd
	task automatic bad(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		acs_seq_model_inst.xfer(w, a, d, r, e);
		check("refused", {31'h0, e}, 32'h1);
		rd(12'h004, acc_m);
		rd(12'h010, 32'(f_m));
		rd(12'h014, stk[0]);
	endtask : bad
	task automatic ld(input logic [31:0] v);
		wr(12'h004, v);
		stk = {stk[6:0], acc_m};
		acc_m = v;
		rd(12'h014, stk[0]);
	endtask : ld
	task automatic wfld(input logic [7:0] s, input logic [5:0] c);
		wr(12'h00C, {18'h0, c, s});
		st = s;
		cnt = c;
		rd(12'h00C, {18'h0, c, s});
	endtask : wfld
	task automatic run(input logic [2:0] o);
		logic [31:0] b;
		b = 32'h0;
		for (int i = 0; i < 32; i++)
			if (i < cnt) b[i] = bm[8'(st + i)];
		wr(12'h000, {29'h0, o});
		case (o)
		3'h1: begin
			acc_m = acc_m ^ stk[0];
			stk = {32'h0, stk[7:1]};
			f_m[4:3] = {acc_m[31], acc_m == 32'h0};
		end
		3'h2: f_m[2:0] = rel({16'h0, acc_m[15:0]}, {16'h0, opnd[15:0]});
		3'h3: f_m[2:0] = rel(acc_m, opnd);
		3'h4: f_m[2:0] = rel(acc_m, b);
		default: f_m[2:0] = rel(acc_m, stk[0]);
		endcase
		@(negedge pclk);
		check("flags", {27'h0, ng, zr, gt, eq, lt}, 32'(f_m));
		rd(12'h004, acc_m);
		rd(12'h014, stk[0]);
	endtask : run

	// ****************************************
	// Clock, watchdog and main sequence
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		repeat (30000) @(posedge pclk);
		miscompares++;
		conclude();
	end
	initial begin
		presetn = 1'b0;
		{acc_m, opnd, stk, bm, f_m, miscompares, n_checks} = '0;
		lf = 32'hBDBDE46B;
		{cnt, st} = 14'h0101;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h010, 32'h0);
		rd(12'h00C, 32'h0000_0101);
		rd(12'h000, 32'h0);
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			wr(12'h100 + 12'(4 * i), lf);
			bm[i * 32 +: 32] = lf;
			rd(12'h100 + 12'(4 * i), lf);
		end
		// Binary operands only, same format on both sides
		for (int k = 0; k < 40; k++) begin
			lf = lfsr(lf);
			ld(lf);
			lf = lfsr(lf);
			ld(k[0] ? lf : acc_m);
			opnd = (k % 3 == 0) ? {~acc_m[31:16], acc_m[15:0]} :
				((k % 3 == 1) ? acc_m : lfsr(lf));
			wr(12'h008, opnd);
			rd(12'h008, opnd);
			wfld(lf[7:0], 6'(1 + lf[12:8]));
			run(3'(1 + k % 5));
		end
		// Refusals leave all state alone
		bad(1'b0, 12'h018, 32'h0);
		bad(1'b1, 12'h010, 32'hFFFF_FFFF);
		bad(1'b1, 12'h014, 32'h1);
		bad(1'b1, 12'h000, 32'h7);
		bad(1'b1, 12'h000, 32'h0);
		bad(1'b0, 12'h120, 32'h0);
		bad(1'b0, 12'h102, 32'h0);
		wfld(8'h05, 6'h00);
		bad(1'b1, 12'h000, 32'h4);
		wfld(8'h05, 6'h21);
		bad(1'b1, 12'h000, 32'h4);
		// Full-width field wrapping past the last bit
		wfld(8'hF0, 6'h20);
		run(3'h4);
		conclude();
	end
endmodule : accum_compare_xor_stack_tb_top
